/* File: hw/dram_ctrl_mode_cmd_status_regs.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module dram_ctrl_mode_cmd_status_regs
   import mode_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire apb_req_type apb_in,
   output apb_rsp_type apb_out,
   // Memory type and calibration status
   input wire logic mem_is_ddr4,
   input wire logic cal_done,
   input wire logic cal_pass,
   // 3DS refresh status
   input wire logic [2:0] refresh_chip_id,
   input wire logic [31:0] refresh_ack,
   // Mode register command to the sequencer
   output logic mrs_req,
   output mrs_cmd_type mrs_cmd,
   input wire logic mrs_done,
   // Command status
   output logic register_command_pending
);

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      IDLE,
      ISSUE,
      GAP
   } seq_state_type;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // One-hot of the lowest set bit
   function automatic logic [3:0] lowest_rank(input logic [3:0] mask);
      logic [3:0] pick;
      pick = mask & (~mask + 4'h1);
      return pick;
   endfunction : lowest_rank

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] idx;
   logic wr_stb;
   logic [31:0] rd_data;
   logic rd_hit;

   logic [2:0] register_command_kind_r;
   logic [3:0] register_command_target_r;
   logic [31:0] register_command_payload_r;

   logic [1:0] cal_flags_r;
   logic [2:0] chip_id_r;
   logic [31:0] ack_vec_r;

   seq_state_type state_r;
   seq_state_type state_nxt;
   logic [3:0] remain_r;
   logic [3:0] remain_nxt;
   logic mrs_req_r;
   logic mrs_req_nxt;
   mrs_cmd_type mrs_cmd_r;
   mrs_cmd_type mrs_cmd_nxt;
   mrs_cmd_type payload_cmd;
   logic pending_r;

   // ----------------------------------------
   // Bus port
   // ----------------------------------------
   apb_port u_apb_port (
      .clk(clk),
      .rst(rst),
      .apb_in(apb_in),
      .apb_out(apb_out),
      .idx(idx),
      .wr_stb(wr_stb),
      .rd_data(rd_data),
      .rd_hit(rd_hit)
   );

   // ----------------------------------------
   // Status capture
   // ----------------------------------------
   cal_status u_cal_status (
      .clk(clk),
      .rst(rst),
      .mem_is_ddr4(mem_is_ddr4),
      .cal_done(cal_done),
      .cal_pass(cal_pass),
      .refresh_chip_id(refresh_chip_id),
      .refresh_ack(refresh_ack),
      .cal_flags_r(cal_flags_r),
      .chip_id_r(chip_id_r),
      .ack_vec_r(ack_vec_r)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire hit_pending = (idx == IDX_PENDING);
   wire hit_kind_target = (idx == IDX_KIND_TARGET);
   wire hit_payload = (idx == IDX_PAYLOAD);
   wire hit_chip_id = (idx == IDX_REFRESH_CHIP_ID);
   wire hit_start = (idx == IDX_START);
   wire hit_cal = (idx == IDX_CAL_RESULT);
   wire hit_width = (idx == IDX_WIDTH_INFO);
   wire hit_version = (idx == IDX_VERSION_INFO);
   wire hit_ack = (idx == IDX_REFRESH_ACK);
   wire high_addr_zero = (apb_in.paddr[11:10] == 2'h0) & (apb_in.paddr[1:0] == 2'h0);

   assign rd_hit = high_addr_zero & (hit_pending | hit_kind_target | hit_payload | hit_chip_id
                   | hit_start | hit_cal | hit_width | hit_version | hit_ack);

   wire wr_kind_target = wr_stb & hit_kind_target;
   wire wr_payload = wr_stb & hit_payload;
   wire wr_start = wr_stb & hit_start & apb_in.pwdata[START_BIT];

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   wire [31:0] rd_pending = 32'(pending_r) << PENDING_BIT;
   wire [31:0] rd_kind_target = (32'(register_command_target_r) << TARGET_LSB)
                                | (32'(register_command_kind_r) << KIND_LSB);
   wire [31:0] rd_chip_id = 32'(chip_id_r) << CHIP_ID_LSB;
   wire [31:0] rd_cal = (32'(cal_flags_r[1]) << CAL_FAIL_BIT)
                        | (32'(cal_flags_r[0]) << CAL_PASS_BIT);
   wire [31:0] rd_width = 32'(WIDTH_INFO_DEFAULT);
   wire [31:0] rd_version = 32'(VERSION_INFO_DEFAULT);

   assign rd_data = ({32{hit_pending}} & rd_pending)
                    | ({32{hit_kind_target}} & rd_kind_target)
                    | ({32{hit_payload}} & register_command_payload_r)
                    | ({32{hit_chip_id}} & rd_chip_id)
                    | ({32{hit_cal}} & rd_cal)
                    | ({32{hit_width}} & rd_width)
                    | ({32{hit_version}} & rd_version)
                    | ({32{hit_ack}} & ack_vec_r);

   // ----------------------------------------
   // Command registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         register_command_kind_r <= KIND_RESET;
         register_command_target_r <= TARGET_RESET;
      end else if (wr_kind_target) begin
         register_command_kind_r <= apb_in.pwdata[KIND_LSB +: 3];
         register_command_target_r <= apb_in.pwdata[TARGET_LSB +: 4];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         register_command_payload_r <= PAYLOAD_RESET;
      end else if (wr_payload) begin
         register_command_payload_r <= apb_in.pwdata;
      end
   end

   // ----------------------------------------
   // Payload split
   // ----------------------------------------
   // Common fields: RAS/CAS/WE, A17 or A14, opcode and bank
   assign payload_cmd.cs = 4'h0;
   assign payload_cmd.ras_n = register_command_payload_r[PL_RAS_BIT];
   assign payload_cmd.cas_n = register_command_payload_r[PL_CAS_BIT];
   assign payload_cmd.we_n = register_command_payload_r[PL_WE_BIT];
   assign payload_cmd.a_hi = register_command_payload_r[PL_AHI_BIT];
   assign payload_cmd.opcode = register_command_payload_r[PL_OPCODE_LSB +: 14];
   assign payload_cmd.ba[1:0] = register_command_payload_r[PL_BA_LSB +: 2];
   // DDR3 carries BA2 at bit 20; for DDR4 that bit is reserved
   assign payload_cmd.ba[2] = ~mem_is_ddr4 & register_command_payload_r[PL_BA2_BIT];
   // DDR4-only fields; reserved for DDR3 and sent as zero
   assign payload_cmd.bg = mem_is_ddr4 ? register_command_payload_r[PL_BG_LSB +: 2] : 2'h0;
   assign payload_cmd.act = mem_is_ddr4 & register_command_payload_r[PL_ACT_BIT];
   assign payload_cmd.cbits = mem_is_ddr4 ? register_command_payload_r[PL_CBITS_LSB +: 3] : 3'h0;

   // ----------------------------------------
   // Command sequencer
   // ----------------------------------------
   // Reserved kinds and an empty target are not started
   wire start_ok = wr_start & (state_r == IDLE)
                   & (register_command_kind_r == KIND_MODE_SET)
                   & (register_command_target_r != 4'h0);

   always_comb begin
      state_nxt = state_r;
      remain_nxt = remain_r;
      mrs_req_nxt = mrs_req_r;
      mrs_cmd_nxt = mrs_cmd_r;
      unique case (state_r)
         IDLE: begin
            if (start_ok) begin
               // Fields are captured here, so later writes cannot disturb the command
               mrs_cmd_nxt = payload_cmd;
               mrs_cmd_nxt.cs = lowest_rank(register_command_target_r);
               remain_nxt = register_command_target_r & ~lowest_rank(register_command_target_r);
               mrs_req_nxt = 1'b1;
               state_nxt = ISSUE;
            end
         end
         ISSUE: begin
            if (mrs_done) begin
               mrs_req_nxt = 1'b0;
               if (remain_r == 4'h0) begin
                  mrs_cmd_nxt.cs = 4'h0;
                  state_nxt = IDLE;
               end else begin
                  state_nxt = GAP;
               end
            end
         end
         GAP: begin
            // Next selected rank, one at a time
            mrs_cmd_nxt.cs = lowest_rank(remain_r);
            remain_nxt = remain_r & ~lowest_rank(remain_r);
            mrs_req_nxt = 1'b1;
            state_nxt = ISSUE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= IDLE;
         remain_r <= 4'h0;
         mrs_req_r <= 1'b0;
         mrs_cmd_r <= '0;
      end else begin
         state_r <= state_nxt;
         remain_r <= remain_nxt;
         mrs_req_r <= mrs_req_nxt;
         mrs_cmd_r <= mrs_cmd_nxt;
      end
   end

   // ----------------------------------------
   // Pending flag
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pending_r <= 1'b0;
      end else begin
         pending_r <= (state_nxt != IDLE);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign mrs_req = mrs_req_r;
   assign mrs_cmd = mrs_cmd_r;
   assign register_command_pending = pending_r;

endmodule : dram_ctrl_mode_cmd_status_regs

/* File: hw/mode_regs_pkg.sv */
// What this block does
// - Command kind field bits 2:0, read/write; 000 is mode register set, others reserved.
// - Target field bits 6:3 picks chip selects; 0001 cs0, 0010 cs1, 0011 both, 1111 all.
// - A mode register set goes to every rank whose target bit is set.
// - DDR4 payload layout: C[26:24], ACT[23], BG[22:21], BA[19:18], A17[17], RAS/CAS/WE[16:14], A[13:0].
// - DDR4 mode register set takes bank group [22:21], bank [19:18], opcode [13:0].
// - DDR3 payload: BA2:BA0 [20:18], A14 [17]; mode set takes bank [20:18], opcode [13:0].
// - Read-only bits 3:1 show the 3DS refresh logical-rank chip ID; unused for DDR3.
// - Calibration result bit 0 reads 1 after successful PHY calibration.
// - Calibration result bit 1 reads 1 after failed PHY calibration.
// - Refresh acknowledge vector holds one byte per physical rank, bit n per logical rank.
// - Read-only pending flag stays high while a mode register command is carried out.
package mode_regs_pkg;

   // ----------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------
   localparam logic [7:0] IDX_PENDING = 8'h31;
   localparam logic [7:0] IDX_KIND_TARGET = 8'h37;
   localparam logic [7:0] IDX_PAYLOAD = 8'h38;
   localparam logic [7:0] IDX_REFRESH_CHIP_ID = 8'h39;
   localparam logic [7:0] IDX_START = 8'h3A;
   localparam logic [7:0] IDX_CAL_RESULT = 8'h3B;
   localparam logic [7:0] IDX_WIDTH_INFO = 8'h44;
   localparam logic [7:0] IDX_VERSION_INFO = 8'h45;
   localparam logic [7:0] IDX_REFRESH_ACK = 8'h4F;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int KIND_LSB = 0;
   localparam int TARGET_LSB = 3;
   localparam int START_BIT = 0;
   localparam int PENDING_BIT = 0;
   localparam int CHIP_ID_LSB = 1;
   localparam int CAL_PASS_BIT = 0;
   localparam int CAL_FAIL_BIT = 1;
   localparam int PL_CBITS_LSB = 24;
   localparam int PL_ACT_BIT = 23;
   localparam int PL_BG_LSB = 21;
   localparam int PL_BA2_BIT = 20;
   localparam int PL_BA_LSB = 18;
   localparam int PL_AHI_BIT = 17;
   localparam int PL_RAS_BIT = 16;
   localparam int PL_CAS_BIT = 15;
   localparam int PL_WE_BIT = 14;
   localparam int PL_OPCODE_LSB = 0;

   // ----------------------------------------
   // Encodings and values after reset
   // ----------------------------------------
   localparam logic [2:0] KIND_MODE_SET = 3'h0;
   localparam logic [2:0] KIND_RESET = 3'h0;
   localparam logic [3:0] TARGET_RESET = 4'h0;
   localparam logic [31:0] PAYLOAD_RESET = 32'h0000_0000;
   localparam logic [15:0] WIDTH_INFO_DEFAULT = 16'h0048;
   // Arbitrary value
   localparam logic [15:0] VERSION_INFO_DEFAULT = 16'h0101;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic [3:0] cs;
      logic [2:0] cbits;
      logic act;
      logic [1:0] bg;
      logic [2:0] ba;
      logic a_hi;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [13:0] opcode;
   } mrs_cmd_type;

endpackage : mode_regs_pkg

/* File: hw/apb_port.sv */
`timescale 1ns/1ps
module apb_port
   import mode_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus
   input wire apb_req_type apb_in,
   output apb_rsp_type apb_out,
   // Register file side
   output logic [7:0] idx,
   output logic wr_stb,
   input wire logic [31:0] rd_data,
   input wire logic rd_hit
);

   logic setup;
   logic access;
   apb_rsp_type rsp_r;

   assign idx = apb_in.paddr[9:2];
   assign setup = apb_in.psel & ~apb_in.penable & ~rsp_r.pready;
   assign access = apb_in.psel & apb_in.penable & rsp_r.pready;
   assign wr_stb = access & apb_in.pwrite & ~rsp_r.pslverr;
   assign apb_out = rsp_r;

   // Answer one cycle after setup; data and error are caught at setup
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_r <= '0;
      end else if (setup) begin
         rsp_r.pready <= 1'b1;
         rsp_r.pslverr <= ~rd_hit;
         rsp_r.prdata <= (apb_in.pwrite | ~rd_hit) ? 32'h0000_0000 : rd_data;
      end else if (access) begin
         rsp_r <= '0;
      end
   end

endmodule : apb_port

/* File: hw/cal_status.sv */
`timescale 1ns/1ps
module cal_status
   import mode_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Controller and PHY status
   input wire logic mem_is_ddr4,
   input wire logic cal_done,
   input wire logic cal_pass,
   input wire logic [2:0] refresh_chip_id,
   input wire logic [31:0] refresh_ack,
   // Captured status
   output logic [1:0] cal_flags_r,
   output logic [2:0] chip_id_r,
   output logic [31:0] ack_vec_r
);

   logic [1:0] cal_flags_nxt;

   assign cal_flags_nxt = cal_done ? {~cal_pass, cal_pass} : 2'h0;

   always_ff @(posedge clk) begin
      if (rst) begin
         cal_flags_r <= 2'h0;
         chip_id_r <= 3'h0;
         ack_vec_r <= 32'h0000_0000;
      end else begin
         cal_flags_r <= cal_flags_nxt;
         chip_id_r <= mem_is_ddr4 ? refresh_chip_id : 3'h0;
         ack_vec_r <= refresh_ack;
      end
   end

endmodule : cal_status

/* File: tb/mode_regs_props.sv */
`timescale 1ns/1ps
module mode_regs_props
   import mode_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire apb_req_type apb_in,
   input wire apb_rsp_type apb_out,
   // Status inputs
   input wire logic mem_is_ddr4,
   input wire logic cal_done,
   input wire logic cal_pass,
   input wire logic [2:0] refresh_chip_id,
   input wire logic [31:0] refresh_ack,
   // Sequencer handshake
   input wire logic mrs_req,
   input wire mrs_cmd_type mrs_cmd,
   input wire logic mrs_done,
   input wire logic register_command_pending
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   localparam logic [11:0] A_CAL = {2'b00, IDX_CAL_RESULT, 2'b00};
   localparam logic [11:0] A_CID = {2'b00, IDX_REFRESH_CHIP_ID, 2'b00};
   localparam logic [11:0] A_ACK = {2'b00, IDX_REFRESH_ACK, 2'b00};
   wire rd_setup = apb_in.psel && !apb_in.penable && !apb_in.pwrite;
   wire [1:0] cal_exp = {cal_done && !cal_pass, cal_done && cal_pass};
   wire [2:0] cid_exp = mem_is_ddr4 ? refresh_chip_id : 3'h0;
   a_cal_flags: assert property (
      rd_setup && apb_in.paddr == A_CAL |=> apb_out.prdata[1:0] == $past(cal_exp, 2))
      else $error("calibration flags wrong");
   a_cal_exclusive: assert property (
      apb_out.pready && apb_in.paddr == A_CAL |-> apb_out.prdata[1:0] != 2'b11)
      else $error("pass and fail both set");
   a_chip_id: assert property (
      rd_setup && apb_in.paddr == A_CID |=> apb_out.prdata[3:1] == $past(cid_exp, 2))
      else $error("chip id wrong");
   a_ack_vector: assert property (
      rd_setup && apb_in.paddr == A_ACK |=> apb_out.prdata == $past(refresh_ack, 2))
      else $error("ack vector wrong");
   a_req_pending: assert property (mrs_req |-> register_command_pending)
      else $error("request without pending");
   a_pending_ends: assert property ($fell(register_command_pending) |-> $past(mrs_done))
      else $error("pending fell early");
   a_cs_onehot: assert property (mrs_req |-> $onehot(mrs_cmd.cs))
      else $error("chip select not one-hot");
   a_cmd_holds: assert property (mrs_req && !mrs_done |=> mrs_req && $stable(mrs_cmd))
      else $error("command moved while waiting");
   a_req_drops: assert property (mrs_req && mrs_done |=> !mrs_req)
      else $error("request held after done");
endmodule : mode_regs_props

bind dram_ctrl_mode_cmd_status_regs mode_regs_props props (.clk(clk), .rst(rst), .apb_in(apb_in),
   .apb_out(apb_out), .mem_is_ddr4(mem_is_ddr4), .cal_done(cal_done), .cal_pass(cal_pass),
   .refresh_chip_id(refresh_chip_id), .refresh_ack(refresh_ack), .mrs_req(mrs_req),
   .mrs_cmd(mrs_cmd), .mrs_done(mrs_done), .register_command_pending(register_command_pending));

/* File: tb/mrs_sequencer_model.sv */
`timescale 1ns/1ps
module mrs_sequencer_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Command handshake
   input wire logic mrs_req,
   input wire logic [3:0] delay,
   output logic mrs_done
);
   logic [3:0] wait_r;
   // Finishes each rank delay+1 cycles after the request rises
   always_ff @(posedge clk) begin
      if (rst || !mrs_req || mrs_done) begin
         wait_r <= 4'h0;
         mrs_done <= 1'b0;
      end else if (wait_r == delay) begin
         mrs_done <= 1'b1;
      end else begin
         wait_r <= wait_r + 4'h1;
      end
   end
endmodule : mrs_sequencer_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import mode_regs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   apb_req_type apb_in = '0;
   apb_rsp_type apb_out;
   logic mem_is_ddr4 = 1'b1;
   logic cal_done = 1'b0;
   logic cal_pass = 1'b0;
   logic [2:0] refresh_chip_id = 3'h0;
   logic [31:0] refresh_ack = 32'h0;
   logic mrs_req, mrs_done, register_command_pending;
   mrs_cmd_type mrs_cmd, exp_cmd;
   logic [3:0] slow = 4'h0;
   logic [31:0] rd, pl;
   logic err;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   dram_ctrl_mode_cmd_status_regs dut (.clk(clk), .rst(rst), .apb_in(apb_in), .apb_out(apb_out),
      .mem_is_ddr4(mem_is_ddr4), .cal_done(cal_done), .cal_pass(cal_pass),
      .refresh_chip_id(refresh_chip_id), .refresh_ack(refresh_ack), .mrs_req(mrs_req),
      .mrs_cmd(mrs_cmd), .mrs_done(mrs_done), .register_command_pending(register_command_pending));
   mrs_sequencer_model seq (.clk(clk), .rst(rst), .mrs_req(mrs_req), .delay(slow), .mrs_done(mrs_done));
   // ----------------------------------------
   // Bus access and comparison
   // ----------------------------------------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clk);
      apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00}, pwdata: wd};
      @(posedge clk);
      apb_in.penable <= 1'b1;
      do @(posedge clk); while (apb_out.pready !== 1'b1);
      rd = apb_out.prdata;
      err = apb_out.pslverr;
      apb_in <= '0;
   endtask : apb
   task run_cmd(input logic [3:0] tgt, input logic d4, input logic [3:0] dly);
      int n;
      mem_is_ddr4 <= d4;
      slow <= dly;
      apb(1'b1, IDX_PAYLOAD, pl);
      apb(1'b1, IDX_KIND_TARGET, {25'h0, tgt, KIND_MODE_SET});
      apb(1'b1, IDX_START, 32'h1);
      exp_cmd = '{cs: 4'h0, cbits: d4 ? pl[26:24] : 3'h0, act: d4 & pl[23], bg: d4 ? pl[22:21] : 2'h0,
         ba: {~d4 & pl[20], pl[19:18]}, a_hi: pl[17], ras_n: pl[16], cas_n: pl[15], we_n: pl[14],
         opcode: pl[13:0]};
      if (dly != 4'h0) begin
         apb(1'b0, IDX_PENDING, 32'h0);
         check("pending busy", rd, 32'h1);
      end
      n = 0;
      for (int k = 0; k < 4; k++) begin
         if (tgt[k]) begin
            while (mrs_req !== 1'b1 && n < 200) begin
               @(posedge clk);
               n++;
            end
            exp_cmd.cs = 4'h1 << k;
            check("command", {1'b0, mrs_cmd}, {1'b0, exp_cmd});
            check("pending pin", {31'h0, register_command_pending}, 32'h1);
            while (mrs_req === 1'b1 && n < 200) begin
               @(posedge clk);
               n++;
            end
         end
      end
      apb(1'b0, IDX_PENDING, 32'h0);
      check("pending idle", rd, 32'h0);
   endtask : run_cmd
   task stop_test;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         stop_test();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, IDX_WIDTH_INFO, 32'h0);
      check("width", rd, {16'h0, WIDTH_INFO_DEFAULT});
      apb(1'b0, IDX_VERSION_INFO, 32'h0);
      check("version", rd, {16'h0, VERSION_INFO_DEFAULT});
      apb(1'b1, IDX_KIND_TARGET, 32'hFFFF_FFFF);
      apb(1'b0, IDX_KIND_TARGET, 32'h0);
      check("kind target", rd, 32'h0000_007F);
      apb(1'b1, IDX_PAYLOAD, 32'hDEAD_BEEF);
      apb(1'b0, IDX_PAYLOAD, 32'h0);
      check("payload", rd, 32'hDEAD_BEEF);
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, IDX_CAL_RESULT, 32'hFFFF_FFFF);
      apb(1'b0, IDX_CAL_RESULT, 32'h0);
      check("cal running", rd, 32'h0);
      $display("test registers done");
      cal_done <= 1'b1;
      cal_pass <= 1'b1;
      apb(1'b0, IDX_CAL_RESULT, 32'h0);
      check("cal pass", rd, 32'h1);
      cal_pass <= 1'b0;
      refresh_chip_id <= 3'h5;
      refresh_ack <= 32'hA5C3_0F81;
      apb(1'b0, IDX_CAL_RESULT, 32'h0);
      check("cal fail", rd, 32'h2);
      apb(1'b0, IDX_REFRESH_CHIP_ID, 32'h0);
      check("chip id", rd, 32'hA);
      apb(1'b0, IDX_REFRESH_ACK, 32'h0);
      check("ack", rd, 32'hA5C3_0F81);
      mem_is_ddr4 <= 1'b0;
      apb(1'b0, IDX_REFRESH_CHIP_ID, 32'h0);
      check("chip id ddr3", rd, 32'h0);
      $display("test status done");
      for (int i = 0; i < 8; i++) begin
         pl = i[0] ? 32'h05B5_C3A7 : 32'hFA4A_3C58;
         run_cmd(i[1:0] == 2'd3 ? 4'hF : {2'b00, i[1:0] + 2'd1}, i[2], i[0] ? 4'h4 : 4'h0);
      end
      $display("test commands done");
      for (int k = 0; k < 9; k++) begin
         apb(1'b1, IDX_KIND_TARGET, k < 8 ? {25'h0, 4'h1, k[2:0]} : 32'h0);
         // Pass 0 has a legal command but leaves the start bit clear
         apb(1'b1, IDX_START, {31'h7FFF_FFFF, k != 0});
         apb(1'b0, IDX_PENDING, 32'h0);
         check("refused start", {rd[31:1], mrs_req}, 32'h0);
         if (k == 0) apb(1'b1, IDX_KIND_TARGET, 32'h0);
      end
      $display("test refusals done");
      stop_test();
   end
endmodule : tb_top
